// file: verilog/rdpm_pkg.sv
package rdpm_pkg;
    // ****************************************
    // Bus map
    // ****************************************
    localparam logic [31:0] RDPM_ADR_CORE_CTRL = 32'h4000_0200;
    localparam logic [31:0] RDPM_ADR_SEL_LOWER = 32'h4000_0204;
    localparam logic [31:0] RDPM_ADR_SEL_UPPER = 32'h4000_020c;
    localparam logic [31:0] RDPM_ADR_PICK_FLIP = 32'h4000_0210;
    localparam logic [31:0] RDPM_RST_CORE_CTRL = 32'h0000_0000;
    localparam logic [31:0] RDPM_RST_SEL = 32'h0000_0000;
    localparam logic [31:0] RDPM_RST_PICK_FLIP = 32'h0000_0000;
    localparam logic [31:0] RDPM_MASK_CORE_CTRL = 32'h0000_0008;
    localparam logic [31:0] RDPM_MASK_SEL = 32'hbfbf_bfbf;
    localparam logic [31:0] RDPM_MASK_PICK_FLIP = 32'hffff_ffff;
    // ****************************************
    // Field layout
    // ****************************************
    localparam int RDPM_OVR_BIT = 3;
    localparam int RDPM_SEL_LANE = 8;
    localparam int RDPM_SEL_EN_OFS = 7;
    localparam int RDPM_PF_LANE = 4;
    localparam int RDPM_PF_FLIP_OFS = 3;
    localparam int RDPM_NWORD = 8;
    localparam int RDPM_SRC_W = 6;
    localparam int RDPM_PICK_W = 3;
    localparam int RDPM_NSRC = 64;

    typedef logic [RDPM_SRC_W-1:0] rdpm_src_t;
    typedef logic [RDPM_PICK_W-1:0] rdpm_pick_t;

    function automatic logic [31:0] rdpm_merge(input logic [31:0] old, input logic [31:0] dat,
                                               input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction
endpackage

// file: verilog/rdpm_sel_if.sv
`timescale 1ns/1ps
interface rdpm_sel_if;
    import rdpm_pkg::*;
    logic [RDPM_NWORD-1:0] en;
    rdpm_src_t [RDPM_NWORD-1:0] src;
    rdpm_pick_t [RDPM_NWORD-1:0] pick;
    logic [RDPM_NWORD-1:0] flip;
    logic ovr;
    logic [RDPM_NWORD-1:0] ovr_val;
    logic [RDPM_NWORD-1:0] port_nxt;
    modport cfg (output en, src, pick, flip, ovr, ovr_val, input port_nxt);
    modport sel (input en, src, pick, flip, ovr, ovr_val, output port_nxt);
endinterface

// file: verilog/rdpm_lane_mux.sv
`timescale 1ns/1ps
module rdpm_lane_mux import rdpm_pkg::*; (
    rdpm_sel_if.sel bus,
    input wire logic [RDPM_NSRC-1:0][7:0] i_src
);
    // ****************************************
    // One lane per port bit
    // ****************************************
    genvar n;
    generate
        for (n = 0; n < RDPM_NWORD; n++) begin : g_lane
            logic [7:0] word;
            // Disabled word reads zero and its source is ignored
            assign word = bus.en[n] ? i_src[bus.src[n]] : 8'h00;
            // Pick one bit, optionally flipped, unless overridden
            assign bus.port_nxt[n] = bus.ovr ? bus.ovr_val[n] : (word[bus.pick[n]] ^ bus.flip[n]);
        end
    endgenerate
endmodule

// file: verilog/rdpm_top.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module rdpm_top import rdpm_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [31:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [RDPM_NSRC-1:0][7:0] i_probe_src,
    input wire logic [7:0] i_probe_override_val,
    output logic [7:0] o_radio_probe_port
);
    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] core_ctrl_r, core_ctrl_nxt;
    logic [31:0] sel_lower_r, sel_lower_nxt;
    logic [31:0] diag_word_select_upper_r, diag_word_select_upper_nxt;
    logic [31:0] diag_bit_pick_invert_r, diag_bit_pick_invert_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [7:0] port_r, port_nxt;
    logic req;

    assign req = i_ce & i_wb_cyc & i_wb_stb & ~ack_r;

    always_comb begin
        core_ctrl_nxt = core_ctrl_r;
        sel_lower_nxt = sel_lower_r;
        diag_word_select_upper_nxt = diag_word_select_upper_r;
        diag_bit_pick_invert_nxt = diag_bit_pick_invert_r;
        ack_nxt = ack_r;
        rdat_nxt = rdat_r;
        if (i_ce) begin
            ack_nxt = req;
            if (req) begin
                unique case (i_wb_adr)
                    RDPM_ADR_CORE_CTRL: rdat_nxt = core_ctrl_r;
                    RDPM_ADR_SEL_LOWER: rdat_nxt = sel_lower_r;
                    RDPM_ADR_SEL_UPPER: rdat_nxt = diag_word_select_upper_r;
                    RDPM_ADR_PICK_FLIP: rdat_nxt = diag_bit_pick_invert_r;
                    default: rdat_nxt = 32'h0000_0000;
                endcase
            end
            if (req && i_wb_we) begin
                unique case (i_wb_adr)
                    RDPM_ADR_CORE_CTRL: begin
                        core_ctrl_nxt = rdpm_merge(core_ctrl_r, i_wb_dat, i_wb_sel, RDPM_MASK_CORE_CTRL);
                    end
                    RDPM_ADR_SEL_LOWER: begin
                        sel_lower_nxt = rdpm_merge(sel_lower_r, i_wb_dat, i_wb_sel, RDPM_MASK_SEL);
                    end
                    RDPM_ADR_SEL_UPPER: begin
                        diag_word_select_upper_nxt = rdpm_merge(diag_word_select_upper_r, i_wb_dat,
                                                                i_wb_sel, RDPM_MASK_SEL);
                    end
                    RDPM_ADR_PICK_FLIP: begin
                        diag_bit_pick_invert_nxt = rdpm_merge(diag_bit_pick_invert_r, i_wb_dat,
                                                              i_wb_sel, RDPM_MASK_PICK_FLIP);
                    end
                    default: begin
                        core_ctrl_nxt = core_ctrl_r;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            core_ctrl_r <= RDPM_RST_CORE_CTRL;
            sel_lower_r <= RDPM_RST_SEL;
            diag_word_select_upper_r <= RDPM_RST_SEL;
            diag_bit_pick_invert_r <= RDPM_RST_PICK_FLIP;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            core_ctrl_r <= core_ctrl_nxt;
            sel_lower_r <= sel_lower_nxt;
            diag_word_select_upper_r <= diag_word_select_upper_nxt;
            diag_bit_pick_invert_r <= diag_bit_pick_invert_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // ****************************************
    // Lane configuration and port register
    // ****************************************
    rdpm_sel_if sel_bus ();
    logic [63:0] sel_all;
    assign sel_all = {diag_word_select_upper_r, sel_lower_r};

    genvar n;
    generate
        for (n = 0; n < RDPM_NWORD; n++) begin : g_cfg
            assign sel_bus.en[n] = sel_all[n*RDPM_SEL_LANE + RDPM_SEL_EN_OFS];
            assign sel_bus.src[n] = sel_all[n*RDPM_SEL_LANE +: RDPM_SRC_W];
            assign sel_bus.pick[n] = diag_bit_pick_invert_r[n*RDPM_PF_LANE +: RDPM_PICK_W];
            assign sel_bus.flip[n] = diag_bit_pick_invert_r[n*RDPM_PF_LANE + RDPM_PF_FLIP_OFS];
        end
    endgenerate
    assign sel_bus.ovr = core_ctrl_r[RDPM_OVR_BIT];
    assign sel_bus.ovr_val = i_probe_override_val;

    rdpm_lane_mux u_lane_mux (
        .bus(sel_bus.sel),
        .i_src(i_probe_src)
    );

    always_comb begin
        port_nxt = i_ce ? sel_bus.port_nxt : port_r;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            port_r <= 8'h00;
        end else begin
            port_r <= port_nxt;
        end
    end

    assign o_radio_probe_port = port_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_live;
        i_ce && !core_ctrl_r[RDPM_OVR_BIT];
    endsequence

    sequence s_upper_write;
        req && i_wb_we && (i_wb_adr == RDPM_ADR_SEL_UPPER) && i_wb_sel[3];
    endsequence

    sequence s_request;
        i_wb_cyc && i_wb_stb && i_ce && !ack_r;
    endsequence

    word_off_zero_a: assert property (s_live and !diag_word_select_upper_r[31]
        |=> o_radio_probe_port[7] == $past(diag_bit_pick_invert_r[31]))
        else $error("disabled word 7 did not read zero");
    word4_en_pos_a: assert property (s_upper_write ##1 i_ce[*1]
        |-> diag_word_select_upper_r[7] == $past(diag_word_select_upper_r[7]) || $past(i_wb_sel[0]))
        else $error("word 4 enable changed without its byte lane");
    enable_bit_write_a: assert property (s_upper_write |=> diag_word_select_upper_r[31] == $past(i_wb_dat[31]))
        else $error("word 7 enable not at bit 31");
    word7_source_a: assert property (s_live and diag_word_select_upper_r[31]
        |=> o_radio_probe_port[7] == $past(i_probe_src[diag_word_select_upper_r[29:24]][diag_bit_pick_invert_r[30:28]]
            ^ diag_bit_pick_invert_r[31]))
        else $error("word 7 source not followed");
    word4_source_a: assert property (s_live and diag_word_select_upper_r[7]
        |=> o_radio_probe_port[4] == $past(i_probe_src[diag_word_select_upper_r[5:0]][diag_bit_pick_invert_r[18:16]]
            ^ diag_bit_pick_invert_r[19]))
        else $error("word 4 source not followed");
    bit0_pick_a: assert property (s_live and sel_lower_r[7]
        |=> o_radio_probe_port[0] == $past(i_probe_src[sel_lower_r[5:0]][diag_bit_pick_invert_r[2:0]]
            ^ diag_bit_pick_invert_r[3]))
        else $error("port bit 0 pick wrong");
    bit3_pick_a: assert property (s_live and sel_lower_r[31]
        |=> o_radio_probe_port[3] == $past(i_probe_src[sel_lower_r[29:24]][diag_bit_pick_invert_r[14:12]]
            ^ diag_bit_pick_invert_r[15]))
        else $error("port bit 3 pick wrong");
    override_port_a: assert property (i_ce && core_ctrl_r[RDPM_OVR_BIT]
        |=> o_radio_probe_port == $past(i_probe_override_val))
        else $error("override value not on port");
    reset_fields_a: assert property (@(posedge i_clk_sys) $rose(i_resetn)
        |-> diag_word_select_upper_r == 32'h0 && diag_bit_pick_invert_r == 32'h0 && o_radio_probe_port == 8'h00)
        else $error("fields not zero after reset");
    bus_ack_once_a: assert property (s_request |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not a single cycle after request");
endmodule

// file: sim/rdpm_probe_sink.sv
`timescale 1ns/1ps
module rdpm_probe_sink (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_port,
    output logic [7:0] o_seen
);
    // Analyser takes one sample of the port per rising edge
    always_ff @(posedge i_clk_sys) begin
        o_seen <= i_port;
    end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import rdpm_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack;
    logic [63:0][7:0] src = '0;
    logic [7:0] ovv = 8'h0;
    logic [7:0] port;
    logic [7:0] seen;
    logic [7:0] hold_e;
    logic [31:0] lo, up, pf, ctl, rd;
    logic [31:0] amap [5] = '{RDPM_ADR_CORE_CTRL, RDPM_ADR_SEL_LOWER, RDPM_ADR_SEL_UPPER, RDPM_ADR_PICK_FLIP,
                              32'h4000_0208};
    int seed = 94280;
    int fails = 0;
    int n_compared = 0;

    always #25 clk = ~clk;

    rdpm_top DUT (.i_clk_sys(clk), .i_resetn(resetn), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
                  .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
                  .i_probe_src(src), .i_probe_override_val(ovv), .o_radio_probe_port(port));
    rdpm_probe_sink u_sink (.i_clk_sys(clk), .i_port(port), .o_seen(seen));

    // Expected port value from the register images
    function automatic logic [7:0] exp_port(input logic [31:0] l, input logic [31:0] u, input logic [31:0] p,
                                            input logic o);
        logic [7:0] r;
        logic [31:0] w;
        for (int n = 0; n < 8; n++) begin
            w = (n < 4) ? l : u;
            r[n] = w[(n % 4) * 8 + 7] ? src[w[(n % 4) * 8 +: 6]][p[n * 4 +: 3]] : 1'b0;
            r[n] = o ? ovv[n] : r[n] ^ p[n * 4 + 3];
        end
        return r;
    endfunction

    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_port(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ****************************************
    // Classic single bus cycle
    // ****************************************
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge clk);
        if (k >= 50) begin
            fails++;
            $display("BAD bus ack expected 1 seen %b", ack);
            conclude();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf, rd);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, amap[i], 32'h0, 4'hf, rd);
            chk_reg("reset value", 32'h0, rd);
        end
        chk_port("reset port", 8'h00, port);
        // Unmapped write ignored, reserved bits read zero, byte lanes
        wr(32'h4000_0208, 32'hffff_ffff);
        wb(1'b0, 32'h4000_0208, 32'h0, 4'hf, rd);
        chk_reg("unmapped", 32'h0, rd);
        wr(RDPM_ADR_SEL_UPPER, 32'hffff_ffff);
        wb(1'b0, RDPM_ADR_SEL_UPPER, 32'h0, 4'hf, rd);
        chk_reg("upper select", 32'hbfbf_bfbf, rd);
        wr(RDPM_ADR_SEL_UPPER, 32'h0);
        wb(1'b1, RDPM_ADR_SEL_UPPER, 32'hffff_ffff, 4'h4, rd);
        wb(1'b0, RDPM_ADR_SEL_UPPER, 32'h0, 4'hf, rd);
        chk_reg("upper lane 2", 32'h00bf_0000, rd);
        // Top lane alone must leave the word 4 enable untouched
        wb(1'b1, RDPM_ADR_SEL_UPPER, 32'hffff_ffff, 4'h8, rd);
        wb(1'b0, RDPM_ADR_SEL_UPPER, 32'h0, 4'hf, rd);
        chk_reg("upper lane 3", 32'hbfbf_0000, rd);
        // ****************************************
        // Random programming with corner cases
        // ****************************************
        for (int i = 0; i < 150; i++) begin
            for (int g = 0; g < 64; g++) src[g] <= (i == 1) ? 8'hff : 8'($random(seed));
            ovv <= 8'($random(seed));
            lo = $random(seed);
            up = $random(seed);
            pf = $random(seed);
            ctl = {28'h0, (($random(seed) & 3) == 0) && (i > 1), 3'h0};
            if (i == 0) begin
                lo = 32'h7f7f_7f7f;
                up = 32'h3f3f_3f3f;
                pf = 32'h8888_8888;
            end else if (i == 1) begin
                lo = 32'hbfbf_bfbf;
                up = 32'hbfbf_bfbf;
                pf = 32'h7777_7777;
            end
            wr(RDPM_ADR_SEL_LOWER, lo);
            wr(RDPM_ADR_SEL_UPPER, up);
            wr(RDPM_ADR_PICK_FLIP, pf);
            wr(RDPM_ADR_CORE_CTRL, ctl);
            wb(1'b0, RDPM_ADR_PICK_FLIP, 32'h0, 4'hf, rd);
            chk_reg("pick flip", pf, rd);
            wb(1'b0, RDPM_ADR_SEL_UPPER, 32'h0, 4'hf, rd);
            chk_reg("upper select", up & RDPM_MASK_SEL, rd);
            repeat (3) @(posedge clk);
            chk_port("probe port", exp_port(lo, up, pf, ctl[3]), seen);
        end
        // ****************************************
        // Clock enable low freezes bus answer and port
        // ****************************************
        hold_e = exp_port(lo, up, pf, ctl[3]);
        @(posedge clk);
        ce <= 1'b0;
        for (int g = 0; g < 64; g++) src[g] <= ~src[g];
        ovv <= ~ovv;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b1;
        adr <= RDPM_ADR_PICK_FLIP;
        wdat <= ~pf;
        sel <= 4'hf;
        repeat (4) @(posedge clk);
        chk_reg("frozen ack", 32'h0, {31'h0, ack});
        chk_port("frozen port", hold_e, seen);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
        wb(1'b0, RDPM_ADR_PICK_FLIP, 32'h0, 4'hf, rd);
        chk_reg("frozen write", pf, rd);
        repeat (3) @(posedge clk);
        chk_port("thawed port", exp_port(lo, up, pf, ctl[3]), seen);
        conclude();
    end
endmodule
